// ---- demod_pkg.sv ----
package demod_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_MODE_SWITCH = 4'h0;
	localparam logic [3:0] ADDR_GAIN_FILTER = 4'h1;
	localparam logic [3:0] ADDR_REF_DAC     = 4'h2;
	localparam logic [3:0] ADDR_AMP_TRIM    = 4'h3;
	localparam logic [3:0] ADDR_CMP_TRIM    = 4'h4;
	localparam logic [3:0] ADDR_MISC        = 4'h5;
	localparam logic [3:0] ADDR_IRQ_STATUS  = 4'h6;
	localparam logic [3:0] ADDR_IRQ_MASK    = 4'h7;

	// ----------------------------------------------------------------
	// Fields and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] MODE_SWITCH_WMASK = 8'hCF;
	localparam logic [7:0] GAIN_FILTER_WMASK = 8'h3F;
	localparam logic [7:0] TRIM_WMASK        = 8'h9F;
	localparam logic [7:0] MISC_WMASK        = 8'h03;
	localparam logic [7:0] RESET_BYTE        = 8'h00;
	localparam int         TRIM_MODE_BIT     = 7;
	localparam int         DEMOD_OUT_BIT     = 7;
	localparam int         REF_STEPS         = 256;
	localparam logic [7:0] ONE_BYTE          = 8'h01;

	// Irq status bits
	localparam int IRQ_RISE_BIT = 0;
	localparam int IRQ_FALL_BIT = 1;

	// Filter tick: divider from sys_clk to crystal-derived filter clock
	localparam int FLT_DIV_DEFAULT = 64;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_OFF,
		MODE_NONINV,
		MODE_INV,
		MODE_ZERO
	} demod_mode_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	typedef struct packed {
		logic       sw3;
		logic       sw2;
		logic       sw1;
		logic       sw0;
	} switch_t;

	typedef struct packed {
		logic       amp_on;
		logic       cmp_on;
		logic       dac_on;
		logic       flt_on;
	} power_t;

endpackage

// ---- demod_control.sv ----
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
// Operation
// [RULE1] Misc register two-bit field picks one of three comm inputs.
// [RULE2] Raw comparator is debounced; filtered level drives output flag and interrupt.
// [RULE3] Reference DAC code output, step is DAC reference over 256.
// [RULE4] Non-inverting mode with gain zero: unity buffer, switches two, three open.
// [RULE5] Mode 00: demod off, switches one and three on.
// [RULE6] Mode 01: non-inverting, switches zero and three on.
// [RULE7] Mode 10: inverting, switches one and two on.
// [RULE8] Mode 11: zero-volt calibration, switches one and three on.
// [RULE9] Disabled: amplifier, comparator, DAC, filter off; comparator output low.
// [RULE10] Switch bits one turn on; switch three off disables DAC.
// [RULE11] Mode register bits five and four ignore writes, read zero.
// [RULE12] Inverting gain codes give -1 to -50.
// [RULE13] Non-inverting gain codes give 1 to 41.
// [RULE14] Firmware sweeps amplifier trim upward in mode 11, watching status.
// [RULE15] Firmware sweeps amplifier trim downward, writes averaged trim back.
// [RULE16] Firmware sweeps comparator trim both ways, writes averaged trim back.
// [RULE17] Filter output changes after level stable for selected tick count; zero bypasses.
module demod_control #(
	parameter int FLT_DIV = demod_pkg::FLT_DIV_DEFAULT
) (
	input  wire logic                sys_clk_i,
	input  wire logic                rst_i,
	input  wire logic [3:0]          addr_i,
	input  wire logic [7:0]          wdata_i,
	input  wire logic                wr_i,
	input  wire logic                rd_i,
	input  wire logic                raw_comparator_out_i,
	output logic      [7:0]          rdata_o,
	output logic      [1:0]          input_source_sel_o,
	output demod_pkg::switch_t       switch_en_o,
	output demod_pkg::power_t        power_en_o,
	output logic      [7:0]          reference_dac_code_o,
	output logic      [2:0]          amp_gain_code_o,
	output logic                     gain_negative_o,
	output logic                     unity_buffer_o,
	output logic                     amp_trim_mode_o,
	output logic      [4:0]          amp_trim_code_o,
	output logic                     cmp_trim_mode_o,
	output logic      [4:0]          cmp_trim_code_o,
	output logic                     filtered_demod_out_o,
	output logic                     demod_irq_trigger_o,
	output logic                     irq_o
);

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	demod_pkg::reg_req_t req;
	logic [7:0] mode_switch_ctrl;
	logic [7:0] gain_filter_ctrl;
	logic [7:0] ref_code;
	logic [7:0] amp_trim_reg;
	logic [7:0] cmp_trim_reg;
	logic [7:0] misc_control_reg;
	logic [7:0] irq_status;
	logic [7:0] irq_mask;
	logic       filt_q;
	logic       next_filt;
	logic       cmp_sync1;
	logic       cmp_sync2;
	logic       cmp_gated;
	logic       demod_on;
	logic       irq_rise;
	logic       irq_fall;
	logic [7:0] stable_cnt;
	logic [7:0] stable_need;
	logic [$clog2(FLT_DIV+1)-1:0] div_cnt;
	logic       flt_tick;
	demod_pkg::demod_mode_t mode;
	demod_pkg::switch_t     next_sw;

	assign req  = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
	assign mode = demod_pkg::demod_mode_t'(mode_switch_ctrl[7:6]);

	// Write decode shared by every writable register
	function automatic logic hit(input demod_pkg::reg_req_t r, input logic [3:0] a);
		hit = r.wr && (r.addr == a);
	endfunction

	// Mode/switch register; unused middle bits masked
	// [RULE11] Reserved bits dropped
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			mode_switch_ctrl <= demod_pkg::RESET_BYTE;
		else if (hit(req, demod_pkg::ADDR_MODE_SWITCH))
			mode_switch_ctrl <= req.wdata & demod_pkg::MODE_SWITCH_WMASK;
	end

	// Gain and filter select; bit 7 is the live filtered flag, not stored
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			gain_filter_ctrl <= demod_pkg::RESET_BYTE;
		else if (hit(req, demod_pkg::ADDR_GAIN_FILTER))
			gain_filter_ctrl <= req.wdata & demod_pkg::GAIN_FILTER_WMASK;
	end

	// [RULE3] Reference DAC code
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			ref_code <= demod_pkg::RESET_BYTE;
		else if (hit(req, demod_pkg::ADDR_REF_DAC))
			ref_code <= req.wdata;
	end

	// [RULE14] Amplifier trim held for firmware sweep
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			amp_trim_reg <= demod_pkg::RESET_BYTE;
		else if (hit(req, demod_pkg::ADDR_AMP_TRIM))
			amp_trim_reg <= req.wdata & demod_pkg::TRIM_WMASK;
	end

	// [RULE16] Comparator trim held for firmware sweep
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			cmp_trim_reg <= demod_pkg::RESET_BYTE;
		else if (hit(req, demod_pkg::ADDR_CMP_TRIM))
			cmp_trim_reg <= req.wdata & demod_pkg::TRIM_WMASK;
	end

	// [RULE1] Input source select
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			misc_control_reg <= demod_pkg::RESET_BYTE;
		else if (hit(req, demod_pkg::ADDR_MISC))
			misc_control_reg <= req.wdata & demod_pkg::MISC_WMASK;
	end

	// Interrupt mask
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			irq_mask <= demod_pkg::RESET_BYTE;
		else if (hit(req, demod_pkg::ADDR_IRQ_MASK))
			irq_mask <= req.wdata;
	end

	// Sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			irq_status <= demod_pkg::RESET_BYTE;
		else
		begin
			irq_status <= (irq_status
				& ~(hit(req, demod_pkg::ADDR_IRQ_STATUS) ? req.wdata : demod_pkg::RESET_BYTE))
				| ({7'h00, irq_rise} << demod_pkg::IRQ_RISE_BIT)
				| ({7'h00, irq_fall} << demod_pkg::IRQ_FALL_BIT);
		end
	end

	// Read data, one cycle after the strobe, zero otherwise
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			rdata_o <= demod_pkg::RESET_BYTE;
		else if (!req.rd)
			rdata_o <= demod_pkg::RESET_BYTE;
		else if (req.addr == demod_pkg::ADDR_MODE_SWITCH)
			rdata_o <= mode_switch_ctrl;
		else if (req.addr == demod_pkg::ADDR_GAIN_FILTER)
			rdata_o <= {filt_q, gain_filter_ctrl[6:0]};
		else if (req.addr == demod_pkg::ADDR_REF_DAC)
			rdata_o <= ref_code;
		else if (req.addr == demod_pkg::ADDR_AMP_TRIM)
			rdata_o <= amp_trim_reg;
		else if (req.addr == demod_pkg::ADDR_CMP_TRIM)
			rdata_o <= cmp_trim_reg;
		else if (req.addr == demod_pkg::ADDR_MISC)
			rdata_o <= {cmp_gated, 5'h00, misc_control_reg[1:0]};
		else if (req.addr == demod_pkg::ADDR_IRQ_STATUS)
			rdata_o <= irq_status;
		else if (req.addr == demod_pkg::ADDR_IRQ_MASK)
			rdata_o <= irq_mask;
		else
			rdata_o <= demod_pkg::RESET_BYTE;
	end

	// ----------------------------------------------------------------
	// Analog control
	// ----------------------------------------------------------------
	assign demod_on = (mode != demod_pkg::MODE_OFF);

	// Switch pattern from mode, then per-bit overrides from the register
	always_comb
	begin
		next_sw = '{sw3: mode_switch_ctrl[3], sw2: mode_switch_ctrl[2],
			sw1: mode_switch_ctrl[1], sw0: mode_switch_ctrl[0]};
		case (mode)
			// [RULE5] Off pattern
			demod_pkg::MODE_OFF:
				next_sw = next_sw
					| demod_pkg::switch_t'{sw3: 1'b1, sw2: 1'b0, sw1: 1'b1, sw0: 1'b0};
			// [RULE6] Non-inverting pattern
			demod_pkg::MODE_NONINV:
				next_sw = next_sw
					| demod_pkg::switch_t'{sw3: 1'b1, sw2: 1'b0, sw1: 1'b0, sw0: 1'b1};
			// [RULE7] Inverting pattern
			demod_pkg::MODE_INV:
				next_sw = next_sw
					| demod_pkg::switch_t'{sw3: 1'b0, sw2: 1'b1, sw1: 1'b1, sw0: 1'b0};
			// [RULE8] Zero-volt pattern
			default:
				next_sw = next_sw
					| demod_pkg::switch_t'{sw3: 1'b1, sw2: 1'b0, sw1: 1'b1, sw0: 1'b0};
		endcase
		// [RULE4] Unity buffer opens two and three
		if (mode == demod_pkg::MODE_NONINV && gain_filter_ctrl[5:3] == 3'h0)
		begin
			next_sw.sw2 = 1'b0;
			next_sw.sw3 = 1'b0;
		end
	end

	// Registered analog controls
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			switch_en_o          <= '0;
			power_en_o           <= '0;
			reference_dac_code_o <= demod_pkg::RESET_BYTE;
			input_source_sel_o   <= 2'h0;
			unity_buffer_o       <= 1'b0;
			gain_negative_o      <= 1'b0;
			amp_gain_code_o      <= 3'h0;
		end
		else
		begin
			// [RULE10] Switch bits drive switches
			switch_en_o          <= next_sw;
			// [RULE9] Power down when disabled
			power_en_o.amp_on    <= demod_on;
			power_en_o.cmp_on    <= demod_on;
			power_en_o.flt_on    <= demod_on;
			// [RULE10] Switch three gates DAC
			power_en_o.dac_on    <= demod_on && mode_switch_ctrl[3];
			// [RULE3] DAC step is vref over 256
			reference_dac_code_o <= ref_code;
			// [RULE1] Comm input routing
			input_source_sel_o   <= misc_control_reg[1:0];
			// [RULE4] Unity buffer flag
			unity_buffer_o       <= (mode == demod_pkg::MODE_NONINV)
				&& (gain_filter_ctrl[5:3] == 3'h0);
			// [RULE12] Inverting gain sign
			gain_negative_o      <= (mode == demod_pkg::MODE_INV);
			// [RULE13] Gain code to amplifier
			amp_gain_code_o      <= gain_filter_ctrl[5:3];
		end
	end

	// [RULE15] Trim codes go out as written
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			amp_trim_mode_o <= 1'b0;
			amp_trim_code_o <= 5'h00;
			cmp_trim_mode_o <= 1'b0;
			cmp_trim_code_o <= 5'h00;
		end
		else
		begin
			amp_trim_mode_o <= amp_trim_reg[demod_pkg::TRIM_MODE_BIT];
			amp_trim_code_o <= amp_trim_reg[4:0];
			cmp_trim_mode_o <= cmp_trim_reg[demod_pkg::TRIM_MODE_BIT];
			cmp_trim_code_o <= cmp_trim_reg[4:0];
		end
	end

	// ----------------------------------------------------------------
	// Comparator debounce
	// ----------------------------------------------------------------
	// Comparator is asynchronous to sys_clk, two-stage synchroniser
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cmp_sync1 <= 1'b0;
			cmp_sync2 <= 1'b0;
		end
		else
		begin
			cmp_sync1 <= raw_comparator_out_i;
			cmp_sync2 <= cmp_sync1;
		end
	end

	// [RULE9] Comparator forced low while off
	assign cmp_gated = cmp_sync2 && demod_on;

	// Filter tick divider stands in for the crystal-derived filter clock
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			div_cnt <= '0;
		else if (flt_tick)
			div_cnt <= '0;
		else
			div_cnt <= div_cnt + 1'b1;
	end
	assign flt_tick = (div_cnt == ($clog2(FLT_DIV+1))'(FLT_DIV - 1));

	// Window length: 2^code ticks, minimum stable count per filter code
	assign stable_need = demod_pkg::ONE_BYTE << gain_filter_ctrl[2:0];

	// [RULE17] Stability counter restarts on any change
	// Also restart as the output flips, else a quick return would pass unfiltered
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			stable_cnt <= demod_pkg::RESET_BYTE;
		else if (cmp_gated == filt_q || next_filt != filt_q)
			stable_cnt <= demod_pkg::RESET_BYTE;
		else if (flt_tick && stable_cnt != stable_need)
			stable_cnt <= stable_cnt + 8'h01;
	end

	// [RULE17] Bypass on code zero, else wait for full window
	always_comb
	begin
		next_filt = filt_q;
		if (gain_filter_ctrl[2:0] == 3'h0)
			next_filt = cmp_gated;
		else if (stable_cnt == stable_need)
			next_filt = cmp_gated;
	end

	// [RULE2] Filtered flag and trigger pulse
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			filt_q               <= 1'b0;
			filtered_demod_out_o <= 1'b0;
			demod_irq_trigger_o  <= 1'b0;
			irq_o                <= 1'b0;
		end
		else
		begin
			filt_q               <= next_filt;
			filtered_demod_out_o <= next_filt;
			demod_irq_trigger_o  <= next_filt != filt_q;
			irq_o                <= |(irq_status & irq_mask);
		end
	end

	assign irq_rise = next_filt && !filt_q;
	assign irq_fall = !next_filt && filt_q;

endmodule // demod_control

// ---- demod_front_model.sv ----
`timescale 1ns/1ns
// Analog front end: the comparator trips once a trim code reaches TRIP
module demod_front_model #(
	parameter int TRIP = 13
) (
	input  wire demod_pkg::power_t power_en_i,
	input  wire logic              amp_trim_mode_i,
	input  wire logic [4:0]        amp_trim_code_i,
	input  wire logic              cmp_trim_mode_i,
	input  wire logic [4:0]        cmp_trim_code_i,
	input  wire logic              level_i,
	output logic                   raw_o
);
	always_comb
		if (!power_en_i.cmp_on)
			raw_o = 1'b0;
		else if (amp_trim_mode_i)
			raw_o = amp_trim_code_i >= TRIP;
		else if (cmp_trim_mode_i)
			raw_o = cmp_trim_code_i >= TRIP;
		else
			raw_o = level_i;
endmodule // demod_front_model

// ---- demod_control_props.sv ----
`timescale 1ns/1ns
module demod_control_props (
	input wire logic              sys_clk_i,
	input wire logic              rst_i,
	input wire logic [3:0]        addr_i,
	input wire logic [7:0]        wdata_i,
	input wire logic              wr_i,
	input wire logic              rd_i,
	input wire logic [7:0]        rdata_o,
	input wire demod_pkg::switch_t switch_en_o,
	input wire demod_pkg::power_t  power_en_o,
	input wire logic [7:0]        reference_dac_code_o,
	input wire logic [2:0]        amp_gain_code_o,
	input wire logic              gain_negative_o,
	input wire logic              unity_buffer_o,
	input wire logic              filtered_demod_out_o,
	input wire logic              demod_irq_trigger_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	logic [7:0] mode_sh, gain_sh, ref_sh;
	logic       settled;
	// Shadows; outputs lag them by one edge, so wait one edge after reset
	always_ff @(posedge sys_clk_i or posedge rst_i)
		if (rst_i)
		begin
			mode_sh <= 8'h00;
			gain_sh <= 8'h00;
			ref_sh <= 8'h00;
			settled <= 1'b0;
		end
		else
		begin
			settled <= 1'b1;
			if (wr_i && addr_i == 4'h0)
				mode_sh <= wdata_i;
			if (wr_i && addr_i == 4'h1)
				gain_sh <= wdata_i;
			if (wr_i && addr_i == 4'h2)
				ref_sh <= wdata_i;
		end
	// Mode pattern, overrides added, unity buffer opens two and three
	function automatic logic [3:0] sw_exp(input logic [7:0] m, input logic [7:0] g);
		logic [3:0] p;
		p = (m[7:6] == 2'b01) ? 4'h9 : (m[7:6] == 2'b10) ? 4'h6 : 4'hA;
		p = p | m[3:0];
		return (m[7:6] == 2'b01 && g[5:3] == 3'h0) ? (p & 4'h3) : p;
	endfunction
	sequence read_mode;
		rd_i && addr_i == 4'h0;
	endsequence
	sequence read_gain;
		rd_i && addr_i == 4'h1;
	endsequence
	a_switch_decode: assert property (
		settled |-> switch_en_o == sw_exp($past(mode_sh), $past(gain_sh)))
		else $error("switch enables wrong for mode");
	a_power_state: assert property (settled |-> ((power_en_o == 4'h0) ==
		($past(mode_sh[7:6]) == 2'b00))) else $error("power enables wrong for mode");
	a_dac_gated: assert property (settled |-> power_en_o.dac_on ==
		($past(mode_sh[3]) && $past(mode_sh[7:6]) != 2'b00)) else $error("dac enable wrong");
	a_unity_buffer: assert property (settled |-> unity_buffer_o ==
		($past(mode_sh[7:6]) == 2'b01 && $past(gain_sh[5:3]) == 3'h0)) else $error("unity flag");
	a_gain_sign: assert property (settled |-> gain_negative_o ==
		($past(mode_sh[7:6]) == 2'b10)) else $error("gain sign wrong");
	a_gain_code: assert property (settled |->
		amp_gain_code_o == $past(gain_sh[5:3])) else $error("gain code wrong");
	a_ref_code: assert property (settled |-> reference_dac_code_o == $past(ref_sh))
		else $error("reference code wrong");
	a_reserved_zero: assert property (read_mode |=> rdata_o[5:4] == 2'b00)
		else $error("reserved bits read nonzero");
	a_flag_readback: assert property (read_gain |=>
		rdata_o[7] == $past(filtered_demod_out_o)) else $error("filtered flag read wrong");
	a_irq_pulse: assert property (demod_irq_trigger_o |=> !demod_irq_trigger_o)
		else $error("trigger longer than one cycle");
	a_irq_follows: assert property ($changed(filtered_demod_out_o) |-> ##[0:1]
		demod_irq_trigger_o) else $error("no trigger on filtered change");
endmodule // demod_control_props

bind demod_control demod_control_props u_props (.sys_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i,
	.rd_i, .rdata_o, .switch_en_o, .power_en_o, .reference_dac_code_o, .amp_gain_code_o,
	.gain_negative_o,
	.unity_buffer_o, .filtered_demod_out_o, .demod_irq_trigger_o);

// ---- demod_control_tb.sv ----
`timescale 1ns/1ns
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module demod_control_tb;
	localparam int TRIP = 13;
	logic clk = 0, rst = 1, wr = 0, rd = 0, rd_seen = 0, level = 0, st, s0;
	logic [3:0]  addr = 4'h0;
	logic [7:0]  wdata = 8'h00, rdata, last_rd;
	logic [31:0] lfsr = 32'h8177;
	logic [15:0] note, expq[$];
	logic        raw, irq, atm, ctm;
	logic [1:0]  sel;
	logic [4:0]  acode, ccode;
	demod_pkg::power_t pwr;
	int fails = 0, samples_checked = 0, v1, v2;
	always #2 clk = ~clk;
	demod_control #(.FLT_DIV(2)) DUT (.sys_clk_i(clk), .rst_i(rst), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .raw_comparator_out_i(raw), .rdata_o(rdata),
		.input_source_sel_o(sel), .switch_en_o(), .power_en_o(pwr), .reference_dac_code_o(),
		.amp_gain_code_o(), .gain_negative_o(), .unity_buffer_o(), .amp_trim_mode_o(atm),
		.amp_trim_code_o(acode), .cmp_trim_mode_o(ctm), .cmp_trim_code_o(ccode),
		.filtered_demod_out_o(), .demod_irq_trigger_o(), .irq_o(irq));
	demod_front_model #(.TRIP(TRIP)) front (.power_en_i(pwr), .amp_trim_mode_i(atm),
		.amp_trim_code_i(acode), .cmp_trim_mode_i(ctm), .cmp_trim_code_i(ccode),
		.level_i(level), .raw_o(raw));
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	// Each signal is assigned once per edge, so back to back cycles are safe
	task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= d;
		@(posedge clk);
	endtask
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask
	task automatic idle(input int n);
		repeat (n) bus(1'b0, 1'b0, 4'h0, 8'h00);
	endtask
	task automatic rreg(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
		expq.push_back({m, e & m});
		bus(1'b0, 1'b1, a, 8'h00);
	endtask
	// Firmware poll of the comparator status; the sync chain needs time
	task automatic stat(output logic s);
		idle(8);
		rreg(4'h5, 8'h00, 8'h00);
		idle(2);
		s = last_rd[demod_pkg::DEMOD_OUT_BIT];
	endtask
	task automatic conclude();
		$display("fails %0d samples_checked %0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Answers come back in issue order, oldest note first
	always @(posedge clk)
	begin
		if (rd_seen)
		begin
			note = expq.pop_front();
			last_rd = rdata;
			`CHK("rdata", note[7:0], rdata & note[15:8])
		end
		rd_seen <= rd;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		fails++;
		conclude();
	end
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int a = 0; a < 16; a++)
			rreg(a[3:0], 8'h00, 8'hFF);
		// Every mode, random overrides, unity case when gain is zero
		for (int m = 0; m < 8; m++)
		begin
			v1 = rnd();
			wreg(4'h0, {m[1:0], 2'b11, v1[3:0]});
			wreg(4'h1, {2'b11, m[2] ? v1[10:8] : 3'h0, 3'h0});
			rreg(4'h0, {m[1:0], 2'b00, v1[3:0]}, 8'hFF);
			rreg(4'h1, {2'b00, m[2] ? v1[10:8] : 3'h0, 3'h0}, 8'h7F);
			idle(3);
		end
		wreg(4'h0, 8'h00);
		v1 = rnd();
		wreg(4'h2, v1[7:0]);
		wreg(4'h3, v1[15:8]);
		rreg(4'h2, v1[7:0], 8'hFF);
		rreg(4'h3, v1[15:8] & 8'h9F, 8'hFF);
		// Random trim mode bit would steer the front end away from the level
		wreg(4'h3, 8'h00);
		for (int s = 0; s < 3; s++)
		begin
			wreg(4'h5, {6'h3F, s[1:0]});
			idle(3);
			`CHK("source", s[1:0], sel)
		end
		// Short pulse swallowed by an 8 tick window, long level passes
		wreg(4'h0, 8'h40);
		wreg(4'h7, 8'h01);
		wreg(4'h1, 8'h0B);
		level <= 1'b1;
		idle(6);
		level <= 1'b0;
		idle(30);
		rreg(4'h1, 8'h00, 8'h80);
		`CHK("irq", 1'b0, irq)
		level <= 1'b1;
		idle(40);
		rreg(4'h1, 8'h80, 8'h80);
		rreg(4'h6, 8'h01, 8'h03);
		`CHK("irq", 1'b1, irq)
		wreg(4'h6, 8'h01);
		idle(3);
		`CHK("irq", 1'b0, irq)
		level <= 1'b0;
		idle(40);
		rreg(4'h6, 8'h02, 8'h03);
		`CHK("irq", 1'b0, irq)
		wreg(4'h1, 8'h08);
		level <= 1'b1;
		idle(4);
		rreg(4'h1, 8'h88, 8'hBF);
		// Offset trim sweeps, up from zero then down from all ones
		wreg(4'h0, 8'hC0);
		for (int k = 0; k < 2; k++)
		begin
			v1 = 0;
			v2 = 0;
			for (int c = 0; c < 64; c++)
			begin
				wreg(4'h3 + k[3:0], 8'h80 | (c < 32 ? c[7:0] : 8'(63 - c)));
				stat(st);
				if (c == 0 || c == 32)
					s0 = st;
				else if (st !== s0 && c < 32 && v1 == 0)
					v1 = c;
				else if (st !== s0 && c > 32 && v2 == 0)
					v2 = 63 - c;
			end
			`CHK("trip", TRIP, v1)
			wreg(4'h3 + k[3:0], 8'((v1 + v2) / 2));
			idle(3);
			`CHK("trim", 5'(TRIP - 1), k ? ccode : acode)
		end
		conclude();
	end
endmodule // demod_control_tb
